// ### verilog/cdpwm_consts.svh
`ifndef CDPWM_CONSTS_SVH
`define CDPWM_CONSTS_SVH

// Clock rate and timing figures.
`define CDPWM_CLK_HZ 100000000
`define CDPWM_CLK_NS 10
// Soft-start seconds per farad of timing capacitance.
`define CDPWM_START_S_PER_F 84000
// Dead time: 1.7 ps per ohm plus a 500 ohm offset.
`define CDPWM_DLY_FS_PER_OHM 1700
`define CDPWM_DLY_OFFSET_OHM 500
// Enforced minimum pulse, fixed.
`define CDPWM_MIN_PULSE_NS 200
`define CDPWM_MIN_PULSE_CYC ((`CDPWM_MIN_PULSE_NS + `CDPWM_CLK_NS - 1) / `CDPWM_CLK_NS)
// Switching-frequency bounds.
`define CDPWM_FSW_MIN_HZ 50000
`define CDPWM_FSW_MAX_HZ 225000
`define CDPWM_HALF_MAX (`CDPWM_CLK_HZ / (2 * `CDPWM_FSW_MIN_HZ))
`define CDPWM_HALF_MIN (`CDPWM_CLK_HZ / (2 * `CDPWM_FSW_MAX_HZ))
// Current limit floor in amperes.
`define CDPWM_ILIM_MIN_A 10
// Defaults.
`define CDPWM_SOFT_START_CYC 84000000
`define CDPWM_AUDIO_W 12
`define CDPWM_CNT_W 32

`endif

// ### verilog/cdpwm_pkg.sv
package cdpwm_pkg;
	typedef struct packed {
		logic high_a;
		logic low_a;
		logic high_b;
		logic low_b;
	} cdpwm_gate_t;

	typedef struct packed {
		logic overcurrent;
		logic overtemp;
		logic undervoltage;
		logic standby;
	} cdpwm_fault_t;

	typedef enum logic [3:0] {
		CDPWM_OFF = 4'h1,
		CDPWM_START = 4'h2,
		CDPWM_RUN = 4'h4,
		CDPWM_RETRY = 4'h8
	} cdpwm_state_t;
endpackage

// ### verilog/cdpwm_dead_time.sv
`include "cdpwm_consts.svh"

// Break-before-make for one bridge side: the turning-on switch waits out the
// dead time after its partner has turned off.
module cdpwm_dead_time
	import cdpwm_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic enable_in,
	input wire logic level_in,
	input wire logic [15:0] dead_cyc_in,
	output logic high_out,
	output logic low_out
);
	logic last_level;
	logic [15:0] wait_cnt;
	wire change = level_in != last_level;
	wire waiting = wait_cnt != 16'h0000;
	wire next_high = enable_in && level_in && !change && !waiting;
	wire next_low = enable_in && !level_in && !change && !waiting;

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			last_level <= 1'b0;
			wait_cnt <= 16'h0000;
			high_out <= 1'b0;
			low_out <= 1'b0;
		end else begin
			last_level <= level_in;
			if (change)
				wait_cnt <= dead_cyc_in;
			else if (waiting)
				wait_cnt <= wait_cnt - 16'h0001;
			high_out <= next_high;
			low_out <= next_low;
		end
	end
endmodule

// ### verilog/cdpwm_controller.sv
`include "cdpwm_consts.svh"

module cdpwm_controller
	import cdpwm_pkg::*;
#(
	parameter logic [31:0] SOFT_START_CYC = `CDPWM_SOFT_START_CYC
) (
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic signed [11:0] audio_in,
	input wire logic standby_in,
	input wire logic undervoltage_in,
	input wire logic [15:0] current_in,
	input wire logic [15:0] current_limit_set_in,
	input wire logic overtemp_flag_in,
	input wire logic [15:0] dead_time_setting_in,
	input wire logic [15:0] half_period_in,
	input wire logic [7:0] start_scale_in,
	output logic high_a_out,
	output logic low_a_out,
	output logic high_b_out,
	output logic low_b_out,
	output logic modulating_out,
	output logic [3:0] fault_out
);
	// Two-stage synchronisers for the pins.
	logic [3:0] sync1;
	logic [3:0] sync2;
	cdpwm_fault_t fault;
	logic [15:0] cur_reg;
	logic over_cur;

	wire [3:0] raw_pins = {1'b0, overtemp_flag_in, undervoltage_in,
		standby_in};

	// The limit can only be raised above the internal floor.
	wire [15:0] limit_eff = (current_limit_set_in <
		16'(`CDPWM_ILIM_MIN_A)) ? 16'(`CDPWM_ILIM_MIN_A) :
		current_limit_set_in;

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
			cur_reg <= 16'h0000;
			over_cur <= 1'b0;
			fault <= '0;
		end else begin
			sync1 <= raw_pins;
			sync2 <= sync1;
			cur_reg <= current_in;
			over_cur <= cur_reg > limit_eff;
			fault <= {over_cur, sync2[2], sync2[1], sync2[0]};
		end
	end

	wire any_error = |fault;
	wire uv_off = fault.undervoltage;
	wire trip_off = fault.overcurrent;

	// Timing interval derived from the external setting.
	wire [39:0] start_prod = 40'(SOFT_START_CYC) * 40'(start_scale_in);
	// Saturate rather than wrap when a large scale overflows the timer.
	wire start_sat = start_prod > 40'h00FF_FFFF_FF;
	wire [31:0] start_len = (start_scale_in == 8'h00) ? 32'h0000_0001 :
		start_sat ? 32'hFFFF_FFFF : start_prod[31:0];

	cdpwm_state_t state;
	cdpwm_state_t next_state;
	logic [31:0] timer;
	wire timer_done = timer >= start_len;

	always_comb begin
		next_state = state;
		unique case (state)
			CDPWM_OFF: begin
				if (!any_error)
					next_state = CDPWM_START;
			end
			CDPWM_START: begin
				if (any_error)
					next_state = CDPWM_RETRY;
				else if (timer_done)
					next_state = CDPWM_RUN;
			end
			CDPWM_RUN: begin
				if (any_error)
					next_state = CDPWM_RETRY;
			end
			CDPWM_RETRY: begin
				if (timer_done && !any_error)
					next_state = CDPWM_RUN;
			end
			default: next_state = CDPWM_OFF;
		endcase
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state <= CDPWM_OFF;
			timer <= 32'h0000_0000;
		end else begin
			state <= next_state;
			// Recheck errors each interval
			if (next_state != state || (state == CDPWM_RETRY && timer_done))
				timer <= 32'h0000_0000;
			else
				timer <= timer + 32'h0000_0001;
		end
	end

	wire run = state == CDPWM_RUN;

	// Triangle: up/down counter, half period clamped to the legal range.
	wire [15:0] half_cl = (half_period_in < 16'(`CDPWM_HALF_MIN)) ?
		16'(`CDPWM_HALF_MIN) : (half_period_in > 16'(`CDPWM_HALF_MAX)) ?
		16'(`CDPWM_HALF_MAX) : half_period_in;
	logic [15:0] tri_cnt;
	logic tri_up;
	wire tri_top = tri_up && tri_cnt >= half_cl - 16'h0001;
	wire tri_bot = !tri_up && tri_cnt <= 16'h0001;

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tri_cnt <= 16'h0000;
			tri_up <= 1'b1;
		end else begin
			if (tri_top)
				tri_up <= 1'b0;
			else if (tri_bot)
				tri_up <= 1'b1;
			tri_cnt <= tri_up ? tri_cnt + 16'h0001 : tri_cnt - 16'h0001;
		end
	end

	// Map signed audio onto the triangle span.
	wire [11:0] audio_off = audio_in ^ 12'h800;
	wire [27:0] scaled = 28'(audio_off) * 28'(half_cl);
	wire [15:0] audio_lvl = scaled[27:12];
	wire cmp = audio_lvl > tri_cnt;

	// Over-modulation: a fixed pulse is forced at a triangle apex that the
	// comparator has not crossed, so neither side stays on indefinitely; its width is a constant.
	logic [15:0] force_cnt;
	logic force_lvl;
	wire [15:0] min_pulse = 16'(`CDPWM_MIN_PULSE_CYC);
	wire force_start = tri_top || tri_bot;

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			force_cnt <= 16'h0000;
			force_lvl <= 1'b0;
		end else begin
			if (force_start && (cmp == tri_top)) begin
				force_cnt <= min_pulse;
				force_lvl <= !cmp;
			end else if (force_cnt != 16'h0000)
				force_cnt <= force_cnt - 16'h0001;
		end
	end

	wire pwm = (force_cnt != 16'h0000) ? force_lvl : cmp;

	// Dead time in clock cycles: 1.7 ps per ohm of (500 + setting).
	wire [39:0] dly_fs = 40'(`CDPWM_DLY_FS_PER_OHM) *
		(40'(dead_time_setting_in) + 40'(`CDPWM_DLY_OFFSET_OHM));
	wire [39:0] dly_cyc = (dly_fs + 40'(`CDPWM_CLK_NS * 1000000 - 1)) /
		40'(`CDPWM_CLK_NS * 1000000);
	wire [15:0] dead_cyc = (dly_cyc > 40'h0000_00FFFF) ? 16'hFFFF :
		dly_cyc[15:0];

	wire drive_en = run && !uv_off && !trip_off;
	logic ha;
	logic la;
	logic hb;
	logic lb;

	// Bridged output: side B switches in antiphase to side A.
	cdpwm_dead_time u_side_a (
		.mclk_in(mclk_in),
		.rstn_in(rstn_in),
		.enable_in(drive_en),
		.level_in(pwm),
		.dead_cyc_in(dead_cyc),
		.high_out(ha),
		.low_out(la)
	);

	cdpwm_dead_time u_side_b (
		.mclk_in(mclk_in),
		.rstn_in(rstn_in),
		.enable_in(drive_en),
		.level_in(!pwm),
		.dead_cyc_in(dead_cyc),
		.high_out(hb),
		.low_out(lb)
	);

	// Standby with a healthy supply and no trip parks both outputs high;
	// undervoltage or overcurrent keeps every switch off.
	wire park_high = !run && !uv_off && !trip_off;
	cdpwm_gate_t next_gate;
	assign next_gate.high_a = park_high || (drive_en && ha);
	assign next_gate.low_a = drive_en && la;
	assign next_gate.high_b = park_high || (drive_en && hb);
	assign next_gate.low_b = drive_en && lb;

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			high_a_out <= 1'b0;
			low_a_out <= 1'b0;
			high_b_out <= 1'b0;
			low_b_out <= 1'b0;
			modulating_out <= 1'b0;
			fault_out <= 4'h0;
		end else begin
			high_a_out <= next_gate.high_a;
			low_a_out <= next_gate.low_a;
			high_b_out <= next_gate.high_b;
			low_b_out <= next_gate.low_b;
			modulating_out <= drive_en;
			fault_out <= fault;
		end
	end
endmodule

// ### bench/cdpwm_chk.sv
module cdpwm_chk
	import cdpwm_pkg::*;
#(
	parameter logic [31:0] SOFT_START_CYC = 32'h00000064
) (
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic signed [11:0] audio_in,
	input wire logic standby_in,
	input wire logic undervoltage_in,
	input wire logic [15:0] current_in,
	input wire logic [15:0] current_limit_set_in,
	input wire logic overtemp_flag_in,
	input wire logic [15:0] dead_time_setting_in,
	input wire logic [15:0] half_period_in,
	input wire logic [7:0] start_scale_in,
	input wire logic high_a_out,
	input wire logic low_a_out,
	input wire logic high_b_out,
	input wire logic low_b_out,
	input wire logic modulating_out,
	input wire logic [3:0] fault_out
);
	timeunit 1ns;
	timeprecision 1ns;
	wire [3:0] gates = {high_a_out, low_a_out, high_b_out, low_b_out};
	// Settings below the floor still trip at the floor.
	wire [15:0] lim = (current_limit_set_in < 16'h000A) ? 16'h000A :
		current_limit_set_in;
	wire over_lim = current_in > lim;
	wire parked = (fault_out[0] | fault_out[2]) & ~fault_out[1] & ~fault_out[3];
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);
	sequence uv_held; fault_out[1] [*3]; endsequence
	sequence oc_held; fault_out[3] [*3]; endsequence
	sequence park_held; parked [*3]; endsequence
	shoot_a_a: assert property (!(high_a_out && low_a_out))
		else $error("side a both on");
	shoot_b_a: assert property (!(high_b_out && low_b_out))
		else $error("side b both on");
	uv_off_a: assert property (uv_held |-> gates == 4'h0)
		else $error("gates on under low supply");
	oc_off_a: assert property (oc_held |-> gates == 4'h0)
		else $error("gates on in overcurrent");
	park_high_a: assert property (park_held |-> gates == 4'hA)
		else $error("outputs not parked high");
	no_mod_a: assert property ((|fault_out) [*3] |-> !modulating_out)
		else $error("modulating with a fault");
	ot_set_a: assert property (overtemp_flag_in [*5] |-> fault_out[2])
		else $error("overtemp not registered");
	ot_clear_a: assert property (!overtemp_flag_in [*5] |-> !fault_out[2])
		else $error("overtemp not cleared");
	oc_flag_a: assert property (over_lim [*5] |-> fault_out[3])
		else $error("overcurrent not registered");
	sb_flag_a: assert property (standby_in [*5] |-> fault_out[0])
		else $error("standby not registered");
endmodule

bind cdpwm_controller cdpwm_chk #(.SOFT_START_CYC(SOFT_START_CYC)) chk_u (.*);

// ### bench/cdpwm_bridge_model.sv
// Bridge stage: reports its die temperature one cycle late and flags any
// moment where a side would conduct straight through.
module cdpwm_bridge_model
	import cdpwm_pkg::*;
(
	input wire logic mclk_in,
	input wire cdpwm_gate_t gates_in,
	input wire logic hot_in,
	output logic overtemp_flag_out = 1'b0,
	output logic shoot_out
);
	timeunit 1ns;
	timeprecision 1ns;
	always @(posedge mclk_in) begin
		overtemp_flag_out <= hot_in;
	end
	assign shoot_out = (gates_in.high_a & gates_in.low_a) |
		(gates_in.high_b & gates_in.low_b);
endmodule

// ### bench/cdpwm_controller_bench.sv
module cdpwm_controller_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import cdpwm_pkg::*;
	localparam int DEAD = (1700 * (500 + 5000) + 9999999) / 10000000;
	localparam logic [3:0] FBIT [4] = '{4'h1, 4'h2, 4'h8, 4'h4};
	localparam logic [3:0] GEXP [4] = '{4'hA, 4'h0, 4'h0, 4'hA};
	logic mclk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic standby_in = 1'b0;
	logic undervoltage_in = 1'b0;
	logic hot = 1'b0;
	logic overtemp_flag_in;
	logic signed [11:0] audio_in = 12'h000;
	logic [15:0] current_in = 16'h0000;
	logic [15:0] current_limit_set_in = 16'h0000;
	logic [15:0] dead_time_setting_in = 16'h1388;
	logic [15:0] half_period_in = 16'h00FA;
	logic [7:0] start_scale_in = 8'h01;
	logic high_a_out, low_a_out, high_b_out, low_b_out, modulating_out;
	logic [3:0] fault_out;
	wire cdpwm_gate_t gates = {high_a_out, low_a_out, high_b_out, low_b_out};
	wire shoot;
	int errors = 0;
	int n_checks = 0;
	int ha, lo, hb, gap, edges, k;
	cdpwm_controller #(.SOFT_START_CYC(32'h00000064)) dut_u (.*);
	cdpwm_bridge_model bridge_u (.mclk_in(mclk_in), .gates_in(gates),
		.hot_in(hot), .overtemp_flag_out(overtemp_flag_in), .shoot_out(shoot));
	initial begin
		forever #5 mclk_in = ~mclk_in;
	end
	task finish_test;
		if (errors == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task check(input logic [3:0] got, input logic [3:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task wait_mod;
		k = 0;
		while (modulating_out !== 1'b1 && k < 400) begin
			@(negedge mclk_in);
			k++;
		end
	endtask
	// Counts duty, both-off runs and periods over 1000 cycles of one level.
	task measure(input logic signed [11:0] a);
		int run;
		logic p;
		@(posedge mclk_in) audio_in <= a;
		repeat (600) @(negedge mclk_in);
		{ha, lo, hb, gap, edges, run} = '0;
		p = high_a_out;
		repeat (1000) begin
			@(negedge mclk_in);
			ha += int'(high_a_out);
			lo += int'(low_a_out);
			hb += int'(high_b_out);
			edges += int'(high_a_out && !p);
			p = high_a_out;
			run = (high_a_out || low_a_out) ? 0 : run + 1;
			gap = (run > gap) ? run : gap;
			check({3'h0, shoot}, 4'h0);
		end
	endtask
	task drive(input int kind, input logic v);
		@(posedge mclk_in);
		case (kind)
			0: standby_in <= v;
			1: undervoltage_in <= v;
			2: current_in <= v ? 16'h000B : 16'h0000;
			default: hot <= v;
		endcase
	endtask
	task start_up;
		repeat (50) @(negedge mclk_in);
		check({3'h0, modulating_out}, 4'h0);
		check(gates, 4'hA);
		wait_mod();
		check({3'h0, k + 50 >= 95 && k + 50 <= 110}, 4'h1);
	endtask
	task modulation;
		int ha0, hb0;
		measure(12'sh000);
		ha0 = ha;
		hb0 = hb;
		check({3'h0, ha0 > 400 && ha0 < 600}, 4'h1);
		check(edges[3:0], 4'h2);
		measure(12'sh258);
		check({3'h0, ha > ha0 + 50 && hb < hb0}, 4'h1);
		check(gap[3:0], 4'(DEAD + 1));
		// Full negative input never crosses the triangle, so only the
		// forced pulse can turn the high side on: two per window.
		measure(12'sh800);
		check({3'h0, lo > 0}, 4'h1);
		check({3'h0, ha >= 30 && ha <= 40}, 4'h1);
		check(edges[3:0], 4'h2);
		@(posedge mclk_in) half_period_in <= 16'h01F4;
		measure(12'sh000);
		check(edges[3:0], 4'h1);
	endtask
	// The current step uses a zero limit setting so the floor decides the trip.
	task fault(input int kind);
		drive(kind, 1'b1);
		repeat (10) @(negedge mclk_in);
		check(fault_out, FBIT[kind]);
		check(gates, GEXP[kind]);
		repeat (250) @(negedge mclk_in);
		check({3'h0, modulating_out}, 4'h0);
		drive(kind, 1'b0);
		wait_mod();
		check({3'h0, k <= 110}, 4'h1);
	endtask
	initial begin
		#200000;
		errors++;
		finish_test();
	end
	initial begin
		repeat (8) @(posedge mclk_in);
		rstn_in <= 1'b1;
		start_up();
		modulation();
		for (int i = 0; i < 4; i++) begin
			fault(i);
		end
		finish_test();
	end
endmodule
